// [fault_recorder_map.svh]
// register numbers, field positions and fault codes of the fault recorder
`ifndef FAULT_RECORDER_MAP_SVH
`define FAULT_RECORDER_MAP_SVH
`define FSR_REG_NUM 4'h5
`define FAR_REG_NUM 4'h6
`define MINOR_ZERO 4'h0
`define OPC2_DATA 3'h0
`define OPC2_INSTR 3'h1
`define FSR_ZERO_BIT 8
`define DOMAIN_HI 7
`define DOMAIN_LO 4
`define STATUS_HI 3
`define STATUS_LO 0
`define UNP_HI 31
`define UNP_LO 9
`define CODE_ALIGN 4'h1
`define CODE_WALK_L1 4'hc
`define CODE_WALK_L2 4'he
`define CODE_XLAT_SEC 4'h5
`define CODE_XLAT_PAGE 4'h7
`define CODE_DOM_SEC 4'h9
`define CODE_DOM_PAGE 4'hb
`define CODE_PERM_SEC 4'hd
`define CODE_PERM_PAGE 4'hf
`define CODE_EXT 4'h8
`define ZERO_WORD 32'h0000_0000
`define ZERO_NIB 4'h0
`endif

// [fault_recorder_pkg.sv]
// types shared by the fault recorder
package fault_recorder_pkg;
  typedef logic [3:0] faultCode_t;
  typedef logic [3:0] domainIdx_t;
  typedef logic [31:0] word_t;
endpackage : fault_recorder_pkg

// [fault_encoder.sv]
// priority encoder from raw fault flags to status code and domain validity
`timescale 1ns/1ps
`include "fault_recorder_map.svh"
module fault_encoder
  import fault_recorder_pkg::*;
(
  // fault flags of one access
  input wire logic alignFault,
  input wire logic walkAbortL1,
  input wire logic walkAbortL2,
  input wire logic xlatFault,
  input wire logic domFault,
  input wire logic permFault,
  input wire logic extAbort,
  input wire logic pageSize,
  // encoded result
  output logic anyFault,
  output faultCode_t code,
  output logic domainValid
);
  always_comb
  begin
    code = `ZERO_NIB;
    domainValid = 1'b0;
    anyFault = 1'b1;
    if (alignFault)
      code = `CODE_ALIGN;
    else if (walkAbortL1)
      code = `CODE_WALK_L1;
    else if (walkAbortL2)
    begin
      code = `CODE_WALK_L2;
      domainValid = 1'b1;
    end
    else if (xlatFault)
    begin
      code = pageSize ? `CODE_XLAT_PAGE : `CODE_XLAT_SEC;
      domainValid = pageSize;
    end
    else if (domFault)
    begin
      code = pageSize ? `CODE_DOM_PAGE : `CODE_DOM_SEC;
      domainValid = 1'b1;
    end
    else if (permFault)
    begin
      code = pageSize ? `CODE_PERM_PAGE : `CODE_PERM_SEC;
      domainValid = 1'b1;
    end
    else if (extAbort)
      code = `CODE_EXT;
    else
      anyFault = 1'b0;
  end
endmodule : fault_encoder

// [fault_status_address_recorder.sv]
// fault status and fault address registers of the system control coprocessor
`timescale 1ns/1ps
`include "fault_recorder_map.svh"
module fault_status_address_recorder
  import fault_recorder_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // coprocessor register transfer
  input wire logic cpWrite,
  input wire logic cpRead,
  input wire logic [3:0] majorRegField,
  input wire logic [3:0] minor_register_field,
  input wire logic [2:0] secondaryOpcode,
  input wire word_t cpWriteData,
  output word_t cpReadData,
  // fault report from translation logic, one-cycle pulse
  input wire logic faultValid,
  input wire logic faultIsData,
  input wire logic alignFault,
  input wire logic walkAbortL1,
  input wire logic walkAbortL2,
  input wire logic xlatFault,
  input wire logic domFault,
  input wire logic permFault,
  input wire logic extAbort,
  input wire logic pageSize,
  input wire domainIdx_t faultDomain,
  input wire word_t modified_virtual_addr
);
  logic [8:0] data_fault_status_ff;
  logic [8:0] instruction_fault_status_ff;
  word_t fault_address_capture_ff;
  word_t nxt_cpReadData;
  logic anyFault;
  faultCode_t code;
  logic domainValid;
  logic hitStatus;
  logic hitAddr;
  logic selData;
  logic selInstr;
  logic dataEvent;
  logic instrEvent;
  logic [8:0] faultEntry;
  logic [8:0] writeEntry;

  fault_encoder encoder
  (
    .alignFault(alignFault),
    .walkAbortL1(walkAbortL1),
    .walkAbortL2(walkAbortL2),
    .xlatFault(xlatFault),
    .domFault(domFault),
    .permFault(permFault),
    .extAbort(extAbort),
    .pageSize(pageSize),
    .anyFault(anyFault),
    .code(code),
    .domainValid(domainValid)
  );

  // alignment and untranslated external aborts arrive as ordinary flags,
  // so they update the registers like any other fault
  assign dataEvent = faultValid & anyFault & faultIsData;
  assign instrEvent = faultValid & anyFault & ~faultIsData;

  // an invalid domain is stored as zero to keep the field deterministic
  assign faultEntry = {1'b0, domainValid ? faultDomain : `ZERO_NIB, code};

  // bit 8 is forced low on every write
  assign writeEntry = {1'b0, cpWriteData[`DOMAIN_HI:`DOMAIN_LO],
                       cpWriteData[`STATUS_HI:`STATUS_LO]};

  always_comb
  begin
    hitStatus = 1'b0;
    hitAddr = 1'b0;
    if (majorRegField == `FSR_REG_NUM && minor_register_field == `MINOR_ZERO)
      hitStatus = 1'b1;
    else if (majorRegField == `FAR_REG_NUM)
      hitAddr = 1'b1;
  end

  assign selData = hitStatus && secondaryOpcode == `OPC2_DATA;
  assign selInstr = hitStatus && secondaryOpcode == `OPC2_INSTR;

  // a fault in the same cycle as a software write wins: the fault is the
  // newer information and must not be lost
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      data_fault_status_ff <= '0;
    else if (dataEvent)
      data_fault_status_ff <= faultEntry;
    else if (cpWrite && selData)
      data_fault_status_ff <= writeEntry;
  end

  // kept for debuggers; software fault handling reads the data side
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      instruction_fault_status_ff <= '0;
    else if (instrEvent)
      instruction_fault_status_ff <= faultEntry;
    else if (cpWrite && selInstr)
      instruction_fault_status_ff <= writeEntry;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      fault_address_capture_ff <= `ZERO_WORD;
    else if (dataEvent)
      fault_address_capture_ff <= modified_virtual_addr;
    else if (cpWrite && hitAddr)
      fault_address_capture_ff <= cpWriteData;
  end
  // instruction aborts have no branch above, so the address holds

  // upper bits are returned as zero, which is one legal unpredictable value
  always_comb
  begin
    nxt_cpReadData = `ZERO_WORD;
    if (selData)
      nxt_cpReadData = {23'h00_0000, data_fault_status_ff};
    else if (selInstr)
      nxt_cpReadData = {23'h00_0000, instruction_fault_status_ff};
    else if (hitAddr)
      nxt_cpReadData = fault_address_capture_ff;
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      cpReadData <= `ZERO_WORD;
    else if (cpRead)
      cpReadData <= nxt_cpReadData;
  end

  // views for the checks below; only dataCodeView is used by them
  faultCode_t dataCodeView;
  faultCode_t instrCodeView;
  assign dataCodeView = data_fault_status_ff[`STATUS_HI:`STATUS_LO];
  assign instrCodeView = instruction_fault_status_ff[`STATUS_HI:`STATUS_LO];

  // a flag only wins when no flag of higher priority is raised
  logic aboveXlat;
  logic aboveDom;
  logic abovePerm;
  logic aboveExt;
  assign aboveXlat = alignFault | walkAbortL1 | walkAbortL2;
  assign aboveDom = aboveXlat | xlatFault;
  assign abovePerm = aboveDom | domFault;
  assign aboveExt = abovePerm | permFault;

  sequence dataFaultSeq;
    dataEvent;
  endsequence

  sequence instrFaultSeq;
    instrEvent;
  endsequence

  status_bit8_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    cpRead && hitStatus |=> !cpReadData[`FSR_ZERO_BIT])
    else $error("status bit 8 read as one");

  data_code_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    dataFaultSeq |=> data_fault_status_ff[3:0] == $past(code))
    else $error("data status code not captured");

  instr_code_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    instrFaultSeq |=> instruction_fault_status_ff[3:0] == $past(code))
    else $error("instruction status code not captured");

  addr_capture_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    dataFaultSeq |=> fault_address_capture_ff == $past(modified_virtual_addr))
    else $error("fault address not captured");

  addr_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    instrFaultSeq and !(cpWrite && hitAddr)
      |=> $stable(fault_address_capture_ff))
    else $error("prefetch abort changed fault address");

  addr_write_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    cpWrite && hitAddr && !dataEvent
      |=> fault_address_capture_ff == $past(cpWriteData))
    else $error("fault address write lost");

  align_code_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    dataEvent && alignFault
      |=> data_fault_status_ff[3:0] == `CODE_ALIGN)
    else $error("alignment not recorded first");

  walk_l1_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    dataEvent && !alignFault && walkAbortL1
      |=> data_fault_status_ff[7:0] == {`ZERO_NIB, `CODE_WALK_L1})
    else $error("first level walk abort code wrong");

  domain_store_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    dataEvent && domainValid
      |=> data_fault_status_ff[7:4] == $past(faultDomain))
    else $error("domain not stored");

  select_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    cpRead && selInstr |=> cpReadData[8:0] == $past(instruction_fault_status_ff))
    else $error("opcode2 one did not select instruction side");

  walk_l2_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    dataEvent && !alignFault && !walkAbortL1 && walkAbortL2
      |=> dataCodeView == `CODE_WALK_L2)
    else $error("second level walk abort code wrong");

  xlat_sec_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    dataEvent && !aboveXlat && xlatFault && !pageSize
      |=> dataCodeView == `CODE_XLAT_SEC)
    else $error("section translation code wrong");

  xlat_page_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    dataEvent && !aboveXlat && xlatFault && pageSize
      |=> dataCodeView == `CODE_XLAT_PAGE)
    else $error("page translation code wrong");

  dom_sec_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    dataEvent && !aboveDom && domFault && !pageSize
      |=> dataCodeView == `CODE_DOM_SEC)
    else $error("section domain code wrong");

  dom_page_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    dataEvent && !aboveDom && domFault && pageSize
      |=> dataCodeView == `CODE_DOM_PAGE)
    else $error("page domain code wrong");

  perm_sec_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    dataEvent && !abovePerm && permFault && !pageSize
      |=> dataCodeView == `CODE_PERM_SEC)
    else $error("section permission code wrong");

  perm_page_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    dataEvent && !abovePerm && permFault && pageSize
      |=> dataCodeView == `CODE_PERM_PAGE)
    else $error("page permission code wrong");

  ext_code_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    dataEvent && !aboveExt && extAbort
      |=> dataCodeView == `CODE_EXT)
    else $error("external abort code wrong");

  domain_clear_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    dataEvent && !domainValid
      |=> data_fault_status_ff[`DOMAIN_HI:`DOMAIN_LO] == `ZERO_NIB)
    else $error("invalid domain not cleared");

  instr_domain_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    instrEvent && domainValid |=>
      instruction_fault_status_ff[`DOMAIN_HI:`DOMAIN_LO] == $past(faultDomain))
    else $error("instruction side domain not stored");

  bit8_clear_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !data_fault_status_ff[`FSR_ZERO_BIT]
      && !instruction_fault_status_ff[`FSR_ZERO_BIT])
    else $error("stored status bit 8 is set");

  data_write_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    cpWrite && selData && !dataEvent |=> data_fault_status_ff
      == {1'b0, $past(cpWriteData[`DOMAIN_HI:`STATUS_LO])})
    else $error("data status write lost");

  instr_write_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    cpWrite && selInstr && !instrEvent |=> instruction_fault_status_ff
      == {1'b0, $past(cpWriteData[`DOMAIN_HI:`STATUS_LO])})
    else $error("instruction status write lost");

  fault_wins_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    dataEvent && cpWrite && selData
      |=> dataCodeView == $past(code))
    else $error("software write beat a data fault");

  instr_keep_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    instrEvent && !(cpWrite && selData)
      |=> $stable(data_fault_status_ff))
    else $error("prefetch abort changed data status");

  addr_read_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    cpRead && hitAddr
      |=> cpReadData == $past(fault_address_capture_ff))
    else $error("fault address read wrong");

  data_read_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    cpRead && selData |=> cpReadData[`FSR_ZERO_BIT:`STATUS_LO]
      == $past(data_fault_status_ff))
    else $error("data status read wrong");

  upper_zero_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    cpRead && hitStatus
      |=> cpReadData[`UNP_HI:`UNP_LO] == '0)
    else $error("status upper bits not zero");

  read_hold_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !cpRead
      |=> $stable(cpReadData))
    else $error("read data changed without a read");

  unmapped_read_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    cpRead && !hitStatus && !hitAddr
      |=> cpReadData == `ZERO_WORD)
    else $error("unmapped register read not zero");

  minor_block_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    cpWrite && minor_register_field != `MINOR_ZERO && !faultValid
      |=> $stable(data_fault_status_ff))
    else $error("status written with nonzero minor field");

  no_event_a: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !faultValid && !cpWrite
      |=> $stable(fault_address_capture_ff))
    else $error("fault address changed with no event");
endmodule : fault_status_address_recorder

// [core_transfer_model.sv]
// model of the core issuing coprocessor register transfers
`timescale 1ns/1ps
module core_transfer_model
  import fault_recorder_pkg::*;
(
  // clock
  input wire logic core_clk,
  // coprocessor transfer
  output logic cpWrite,
  output logic cpRead,
  output logic [3:0] majorRegField,
  output logic [3:0] minor_register_field,
  output logic [2:0] secondaryOpcode,
  output word_t cpWriteData,
  input wire word_t cpReadData
);
  initial
  begin
    cpWrite = 1'b0;
    cpRead = 1'b0;
    majorRegField = 4'h0;
    minor_register_field = 4'h0;
    secondaryOpcode = 3'h0;
    cpWriteData = 32'h0000_0000;
  end
  // one transfer held for one cycle; minor field is always zero
  task automatic xfer(input logic wr, input logic [3:0] regNum,
    input logic [2:0] op2, input word_t wd, output word_t rd);
    @(posedge core_clk);
    #1;
    cpWrite = wr;
    cpRead = !wr;
    majorRegField = regNum;
    minor_register_field = 4'h0;
    secondaryOpcode = op2;
    cpWriteData = wd;
    @(posedge core_clk);
    #1;
    cpWrite = 1'b0;
    cpRead = 1'b0;
    // released data must not keep showing the last value
    cpWriteData = ~wd;
    rd = cpReadData;
  endtask : xfer
endmodule : core_transfer_model

// [fault_status_address_recorder_bench.sv]
// self-checking bench of the fault status and address recorder
`timescale 1ns/1ps
module fault_status_address_recorder_bench
  import fault_recorder_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cpWrite, cpRead, faultValid = 1'b0, faultIsData = 1'b0;
  logic alignFault, walkAbortL1, walkAbortL2, xlatFault, domFault;
  logic permFault, extAbort, pageSize = 1'b0;
  logic [3:0] majorRegField, minor_register_field;
  logic [2:0] secondaryOpcode;
  domainIdx_t faultDomain = 4'h0;
  word_t cpWriteData, cpReadData, modified_virtual_addr = 32'h0000_0000;
  int errCount = 0, cmpCount = 0, cycles = 0;
  int dfs = 0, ifs = 0, fault_address_capture = 0;
  word_t rd, wd;
  always #4 core_clk = ~core_clk;
  core_transfer_model i_core (.core_clk, .cpWrite, .cpRead,
    .majorRegField, .minor_register_field, .secondaryOpcode,
    .cpWriteData, .cpReadData);
  fault_status_address_recorder i_dut (.core_clk, .sys_rst, .cpWrite,
    .cpRead, .majorRegField, .minor_register_field, .secondaryOpcode,
    .cpWriteData, .cpReadData, .faultValid, .faultIsData, .alignFault,
    .walkAbortL1, .walkAbortL2, .xlatFault, .domFault, .permFault,
    .extAbort, .pageSize, .faultDomain, .modified_virtual_addr);
  initial
    {alignFault, walkAbortL1, walkAbortL2, xlatFault, domFault,
      permFault, extAbort} = 7'h00;
  task automatic chk(input string nm, input word_t seen, input word_t exp);
    cmpCount++;
    if (seen !== exp)
    begin
      errCount++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic readAll();
    i_core.xfer(1'b0, 4'h5, 3'h0, 32'h0000_0000, rd);
    chk("data status", rd, word_t'(dfs));
    i_core.xfer(1'b0, 4'h5, 3'h1, 32'h0000_0000, rd);
    chk("instr status", rd, word_t'(ifs));
    i_core.xfer(1'b0, 4'h6, 3'h0, 32'h0000_0000, rd);
    chk("fault address", rd, word_t'(fault_address_capture));
  endtask : readAll
  // flags in priority order: align, walk1, walk2, xlat, dom, perm, ext
  task automatic fault(input logic dat, input logic [6:0] f, input logic pg);
    int c;
    int dv;
    word_t a;
    logic [3:0] d;
    a = $urandom;
    d = $urandom;
    dv = 1;
    if (f[6]) begin c = 1; dv = 0; end
    else if (f[5]) begin c = 12; dv = 0; end
    else if (f[4]) c = 14;
    else if (f[3]) begin c = pg ? 7 : 5; dv = pg; end
    else if (f[2]) c = pg ? 11 : 9;
    else if (f[1]) c = pg ? 15 : 13;
    else begin c = 8; dv = 0; end
    @(posedge core_clk);
    #1;
    faultValid = 1'b1;
    faultIsData = dat;
    {alignFault, walkAbortL1, walkAbortL2, xlatFault, domFault,
      permFault, extAbort} = f;
    pageSize = pg;
    faultDomain = d;
    modified_virtual_addr = a;
    @(posedge core_clk);
    #1;
    faultValid = 1'b0;
    // flags without a valid pulse must be ignored
    {alignFault, walkAbortL1, walkAbortL2, xlatFault, domFault,
      permFault, extAbort} = $urandom;
    modified_virtual_addr = $urandom;
    if (f != 7'h00 && dat) dfs = (dv ? d << 4 : 0) | c;
    if (f != 7'h00 && dat) fault_address_capture = a;
    if (f != 7'h00 && !dat) ifs = c | (dv ? d << 4 : 0);
  endtask : fault
  task automatic printVerdict();
    $display("counts: %0d compared, %0d mismatched", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : printVerdict
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errCount++;
      printVerdict();
    end
  end
  initial
  begin
    void'($urandom(32'h9fcb_01ad));
    repeat (10) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    readAll();
    $display("reset values done");
    for (int i = 0; i < 28; i++)
    begin
      fault(i[0], 7'h01 << (i / 4), i[1]);
      readAll();
    end
    $display("single faults done");
    repeat (30)
    begin
      fault($urandom, $urandom, $urandom);
      readAll();
    end
    $display("priority done");
    for (int k = 0; k < 2; k++)
    begin
      wd = $urandom | 32'h0000_0100;
      i_core.xfer(1'b1, 4'h5, k[2:0], wd, rd);
      if (k == 0) dfs = wd & 32'h0000_00ff;
      else ifs = wd & 32'h0000_00ff;
    end
    // a status write that meets a data fault is dropped
    fork
      fault(1'b1, 7'h08, 1'b0);
      i_core.xfer(1'b1, 4'h5, 3'h0, ~wd, rd);
    join
    fault_address_capture = $urandom;
    i_core.xfer(1'b1, 4'h6, 3'h0, fault_address_capture, rd);
    readAll();
    i_core.xfer(1'b0, 4'h7, 3'h0, 32'h0000_0000, rd);
    chk("unmapped read", rd, 32'h0000_0000);
    $display("register writes done");
    printVerdict();
  end
endmodule : fault_status_address_recorder_bench
